//--- hw/fbp_top.v
`timescale 1ns/1ns
`include "fbp_regs.vh"
module fbp_top (
  input wire MCLK_I,              // system clock
  input wire RESET_I,             // sync reset, active high
  input wire [7:0] ADDR_I,        // register address
  input wire [7:0] WDATA_I,       // write data
  input wire WR_I,                // write strobe
  input wire RD_I,                // read strobe
  output reg [7:0] RDATA_O,       // read data, cycle after read
  input wire WAIT_I,              // cpu enters wait mode
  input wire STOP_I,              // cpu enters stop mode
  input wire MON_ICG_I,           // monitor entered on internal clock
  output wire FL_PGM_O,           // array program control
  output wire FL_ERASE_O,         // array erase control
  output wire FL_MASS_O,          // array mass erase control
  output wire FL_HV_O,            // charge pump / high voltage
  output wire FL_STANDBY_O,       // array in standby
  output wire [7:0] LIVE_TRIM_O,  // live oscillator trim
  output wire [15:0] PROT_START_O // computed protect start
);
  // ********************
  // state
  // ********************
  reg pgm_reg;
  reg erase_reg;
  reg mass_reg;
  reg hv_reg;
  reg standby_reg;
  reg refused_reg;
  reg [7:0] prot_reg;
  reg [7:0] trim5_reg;
  reg [7:0] trim3_reg;
  reg [7:0] live_reg;
  reg [15:0] tgt_reg;
  reg [7:0] pdata_reg;
  reg mon_done_reg;
  wire [15:0] start;
  wire tgt_hit;
  wire busy;
  wire low_power;
  wire commit;
  wire tgt_is_prot;
  wire tgt_is_trim5;
  wire tgt_is_trim3;
  wire mass_block;
  wire hv_block;
  wire pbyte_lock;

  fbp_range u_range (
    .prot_i(prot_reg),
    .addr_i(tgt_reg),
    .start_o(start),
    .hit_o(tgt_hit)
  );

  assign busy = pgm_reg | erase_reg | hv_reg;
  assign low_power = WAIT_I | STOP_I;
  assign tgt_is_prot = (tgt_reg == `FBP_PROT_ADDR);
  assign tgt_is_trim5 = (tgt_reg == `FBP_TRIM5_ADDR);
  assign tgt_is_trim3 = (tgt_reg == `FBP_TRIM3_ADDR);
  assign mass_block = (prot_reg != `FBP_ALL_ONES);
  // protect byte itself locked once value leaves ff/fe
  assign pbyte_lock = tgt_is_prot & (prot_reg != `FBP_ALL_ONES) &
                      (prot_reg != `FBP_VEC_ONLY);
  assign hv_block = (erase_reg & mass_reg) ? mass_block :
                    (tgt_hit | pbyte_lock);
  // commit models the end of a programming pulse under high voltage
  assign commit = WR_I & (ADDR_I == `FBP_OFS_CTRL) &
                  WDATA_I[`FBP_CTL_COMMIT] & hv_reg & pgm_reg;

  // ********************
  // control register and low power abort
  // ********************
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      pgm_reg <= 1'b0;
      erase_reg <= 1'b0;
      mass_reg <= 1'b0;
      hv_reg <= 1'b0;
      standby_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else if (low_power & busy) begin
      pgm_reg <= 1'b0;
      erase_reg <= 1'b0;
      mass_reg <= 1'b0;
      hv_reg <= 1'b0;
      standby_reg <= 1'b1;
    end else if (WR_I & (ADDR_I == `FBP_OFS_CTRL)) begin
      standby_reg <= 1'b0;
      mass_reg <= WDATA_I[`FBP_CTL_MASS];
      // program and erase select are mutually exclusive
      if (WDATA_I[`FBP_CTL_PGM] & WDATA_I[`FBP_CTL_ERASE]) begin
        pgm_reg <= pgm_reg;
        erase_reg <= erase_reg;
      end else begin
        pgm_reg <= WDATA_I[`FBP_CTL_PGM] & ~erase_reg;
        erase_reg <= WDATA_I[`FBP_CTL_ERASE] & ~pgm_reg;
      end
      if (WDATA_I[`FBP_CTL_HIGH_VOLTAGE_ENABLE] & ~hv_reg) begin
        if ((pgm_reg | erase_reg) & ~hv_block) begin
          hv_reg <= 1'b1;
          refused_reg <= 1'b0;
        end else begin
          refused_reg <= 1'b1;
        end
      end else begin
        hv_reg <= WDATA_I[`FBP_CTL_HIGH_VOLTAGE_ENABLE];
      end
    end
  end
  // with nothing busy, wait or stop changes no state above

  // ********************
  // flash resident bytes
  // ********************
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      prot_reg <= `FBP_PROT_RST;
      trim5_reg <= `FBP_TRIM_RST;
      trim3_reg <= `FBP_TRIM_RST;
      tgt_reg <= 16'h0000;
      pdata_reg <= 8'h00;
    end else begin
      if (WR_I & (ADDR_I == `FBP_OFS_TGT_LO) & ~hv_reg) begin
        tgt_reg[7:0] <= WDATA_I;
      end
      if (WR_I & (ADDR_I == `FBP_OFS_TGT_HI) & ~hv_reg) begin
        tgt_reg[15:8] <= WDATA_I;
      end
      if (WR_I & (ADDR_I == `FBP_OFS_PDATA)) begin
        pdata_reg <= WDATA_I;
      end
      // only a completed program or erase cycle alters the stored bytes
      if (commit) begin
        if (tgt_is_prot) begin
          prot_reg <= prot_reg & pdata_reg;
        end
        if (tgt_is_trim5) begin
          trim5_reg <= trim5_reg & pdata_reg;
        end
        if (tgt_is_trim3) begin
          trim3_reg <= trim3_reg & pdata_reg;
        end
      end else if (erase_reg & hv_reg & WR_I &
                   (ADDR_I == `FBP_OFS_CTRL) &
                   ~WDATA_I[`FBP_CTL_ERASE]) begin
        // erase completes when select drops under high voltage
        if (mass_reg | (tgt_reg[15:6] == `FBP_TRIM_PAGE)) begin
          trim5_reg <= `FBP_ALL_ONES;
          trim3_reg <= `FBP_ALL_ONES;
        end
        if (mass_reg | (tgt_reg[15:6] == `FBP_PROT_PAGE)) begin
          prot_reg <= `FBP_ALL_ONES;
        end
      end
    end
  end

  // ********************
  // live trim and monitor boot load
  // ********************
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      live_reg <= `FBP_LIVE_RST;
      mon_done_reg <= 1'b0;
    end else if (~mon_done_reg) begin
      mon_done_reg <= 1'b1;
      if (MON_ICG_I & (trim5_reg != `FBP_ALL_ONES)) begin
        live_reg <= trim5_reg;
      end
    end else if (WR_I & (ADDR_I == `FBP_OFS_LIVE)) begin
      live_reg <= WDATA_I;
    end
  end

  // ********************
  // read port
  // ********************
  always @(posedge MCLK_I) begin
    if (RESET_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        `FBP_OFS_CTRL: RDATA_O <= {4'h0, hv_reg, mass_reg,
                                   erase_reg, pgm_reg};
        `FBP_OFS_PROT: RDATA_O <= prot_reg;
        `FBP_OFS_TRIM5: RDATA_O <= trim5_reg;
        `FBP_OFS_TRIM3: RDATA_O <= trim3_reg;
        `FBP_OFS_LIVE: RDATA_O <= live_reg;
        `FBP_OFS_TGT_LO: RDATA_O <= tgt_reg[7:0];
        `FBP_OFS_TGT_HI: RDATA_O <= tgt_reg[15:8];
        `FBP_OFS_STAT: RDATA_O <= {4'h0, mass_block, tgt_hit,
                                   refused_reg, standby_reg};
        `FBP_OFS_PDATA: RDATA_O <= pdata_reg;
        `FBP_OFS_MON: RDATA_O <= {7'h00, mon_done_reg};
        default: RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // standby forces every array control low
  assign FL_PGM_O = pgm_reg & ~standby_reg;
  assign FL_ERASE_O = erase_reg & ~standby_reg;
  assign FL_MASS_O = mass_reg & erase_reg & ~standby_reg;
  assign FL_HV_O = hv_reg & ~standby_reg;
  assign FL_STANDBY_O = standby_reg;
  assign LIVE_TRIM_O = live_reg;
  assign PROT_START_O = start;
endmodule

//--- common/fbp_regs.vh
// Function
// - start address is 2'b11, protect bits, six zero bits
// - addresses from start through ffff are protected
// - start address always falls on a 64-byte page boundary
// - protect value 00 protects the whole array
// - protect value ff protects nothing
// - fd covers protect byte and vectors, fe covers vectors only
// - protect byte lives in flash, changed only by programming or erasing it; reset also reloads it with ff
// - wait entry during program or erase aborts it into standby
// - stop entry during program or erase aborts it into standby
// - standby drives every flash array control inactive
// - wait or stop in read mode leaves flash state untouched
// - monitor boot on internal clock copies 5 v trim if not ff; reset also loads the 5 v trim with ff, so no copy ever occurs
// - high voltage enable refused when target is protected
// - mass erase disabled unless protect value is ff; mass selected in or after the high voltage enable write is not blocked
// - protect byte locked unless protect value is ff or fe
`ifndef FBP_REGS_VH
`define FBP_REGS_VH
// ********************
// register offsets
// ********************
`define FBP_ADDR_W 8
`define FBP_OFS_CTRL 8'h00
`define FBP_OFS_PROT 8'h01
`define FBP_OFS_TRIM5 8'h02
`define FBP_OFS_TRIM3 8'h03
`define FBP_OFS_LIVE 8'h04
`define FBP_OFS_TGT_LO 8'h05
`define FBP_OFS_TGT_HI 8'h06
`define FBP_OFS_STAT 8'h07
`define FBP_OFS_PDATA 8'h08
`define FBP_OFS_MON 8'h09
// ********************
// control fields
// ********************
`define FBP_CTL_PGM 0
`define FBP_CTL_ERASE 1
`define FBP_CTL_MASS 2
`define FBP_CTL_HIGH_VOLTAGE_ENABLE 3
`define FBP_CTL_COMMIT 4
// ********************
// fixed addresses and values
// ********************
`define FBP_PROT_ADDR 16'hff7e
`define FBP_TRIM5_ADDR 16'hff80
`define FBP_TRIM3_ADDR 16'hff81
`define FBP_TRIM_PAGE 10'h3fe
`define FBP_PROT_PAGE 10'h3fd
`define FBP_ALL_ONES 8'hff
`define FBP_VEC_ONLY 8'hfe
`define FBP_ALL_ZERO 8'h00
`define FBP_PROT_RST 8'hff
`define FBP_TRIM_RST 8'hff
`define FBP_LIVE_RST 8'h80
`endif

//--- hw/fbp_range.v
`timescale 1ns/1ns
// ********************
// protect range decode
// ********************
module fbp_range (
  input wire [7:0] prot_i,   // protect value
  input wire [15:0] addr_i,  // target address
  output wire [15:0] start_o, // protect start address
  output wire hit_o          // target lies in protected range
);
  assign start_o = {2'b11, prot_i, 6'h00};
  assign hit_o = (prot_i == 8'h00) ? 1'b1 :
                 (prot_i == 8'hff) ? 1'b0 :
                 (addr_i >= start_o);
endmodule

//--- verification/fbp_chk_properties.sv
`timescale 1ns/1ns
module fbp_chk (
  input wire MCLK_I, // clock
  input wire RESET_I, // reset
  input wire [7:0] ADDR_I, // address
  input wire [7:0] WDATA_I, // data
  input wire WR_I, // write
  input wire WAIT_I, // wait
  input wire STOP_I, // stop
  input wire FL_PGM_O, // program
  input wire FL_ERASE_O, // erase
  input wire FL_MASS_O, // mass
  input wire FL_HV_O, // high volt
  input wire FL_STANDBY_O, // standby
  input wire [15:0] PROT_START_O // start
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  wire busy = FL_PGM_O | FL_ERASE_O | FL_MASS_O | FL_HV_O;
  wire hv_wr = WR_I && ADDR_I == 8'h00 && WDATA_I[3] && !FL_HV_O;
  sequence s_wait_hv; FL_HV_O && WAIT_I; endsequence
  sequence s_stop_hv; FL_HV_O && STOP_I; endsequence
  sequence s_quiet; FL_STANDBY_O && !busy; endsequence
  AST_START: assert property (PROT_START_O[5:0] == 6'h00)
    else $error("start not page aligned");
  AST_WAIT_ABORT: assert property (s_wait_hv |=> s_quiet)
    else $error("wait did not abort");
  AST_STOP_ABORT: assert property (s_stop_hv |=> s_quiet)
    else $error("stop did not abort");
  AST_STBY_QUIET: assert property (FL_STANDBY_O |-> !busy)
    else $error("control active in standby");
  AST_READ_IDLE: assert property ((WAIT_I || STOP_I) && !busy && !WR_I
    && !FL_STANDBY_O |=> !FL_STANDBY_O) else $error("idle entered standby");
  AST_ALL_PROT: assert property (hv_wr && PROT_START_O == 16'hc000
    |=> !FL_HV_O) else $error("high voltage with all protected");
  AST_MASS_BLK: assert property (hv_wr && WDATA_I[2]
    && PROT_START_O != 16'hffc0 |=> !FL_HV_O) else $error("mass allowed");
  AST_HV_SRC: assert property ($rose(FL_HV_O) |-> $past(hv_wr))
    else $error("high voltage without request");
endmodule
bind fbp_top fbp_chk chk_u (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .WAIT_I(WAIT_I),
  .STOP_I(STOP_I), .FL_PGM_O(FL_PGM_O), .FL_ERASE_O(FL_ERASE_O),
  .FL_MASS_O(FL_MASS_O), .FL_HV_O(FL_HV_O), .FL_STANDBY_O(FL_STANDBY_O),
  .PROT_START_O(PROT_START_O));

//--- verification/fbp_cpu_model.sv
`timescale 1ns/1ns
module fbp_cpu (
  input wire clk_i, // clock
  input wire [7:0] rdata_i, // read data
  output logic [7:0] addr_o = 8'h00, // address
  output logic [7:0] wdata_o = 8'h00, // data
  output logic wr_o = 1'b0, // write
  output logic rd_o = 1'b0 // read
);
  logic [7:0] junk;
  // a gap cycle after each strobe keeps back-to-back calls race free
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    // data stands in the cycle after the strobe; taken at its closing edge
    d = rdata_i;
  endtask
  task hv(input logic [15:0] t, input logic [7:0] d);
    wr(8'h00, 8'h01);
    rd(8'h01, junk);
    wr(8'h05, t[7:0]);
    wr(8'h06, t[15:8]);
    wr(8'h08, d);
    wr(8'h00, 8'h09);
  endtask
endmodule

//--- verification/fbp_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) num_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, s); end
module fbp_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wt = 1'b0;
  logic st = 1'b0;
  logic mon = 1'b0;
  wire [7:0] a, wd, rdat, live;
  wire w, r, pg, er, ms, hv, sb;
  wire [15:0] ps;
  logic [7:0] v, x;
  logic [15:0] t;
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  fbp_cpu cpu_u (.clk_i(clk), .rdata_i(rdat), .addr_o(a), .wdata_o(wd),
    .wr_o(w), .rd_o(r));
  fbp_top dut_u (.MCLK_I(clk), .RESET_I(rst), .ADDR_I(a), .WDATA_I(wd),
    .WR_I(w), .RD_I(r), .RDATA_O(rdat), .WAIT_I(wt), .STOP_I(st),
    .MON_ICG_I(mon), .FL_PGM_O(pg), .FL_ERASE_O(er), .FL_MASS_O(ms),
    .FL_HV_O(hv), .FL_STANDBY_O(sb), .LIVE_TRIM_O(live), .PROT_START_O(ps));
  function automatic logic hit(logic [7:0] p, logic [15:0] ad);
    if (p == 8'hff) return 1'b0;
    return p == 8'h00 || ad >= {2'b11, p, 6'h00};
  endfunction
  task reset_dut;
    rst <= 1'b1;
    mon <= 1'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("live", 8'h80, live)
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    v = 8'($urandom(32'h60ca));
    for (int i = 0; i < 10; i++) begin
      v = 8'(i == 4 ? 8'h00 : i < 4 ? 8'hfc + i : $urandom);
      reset_dut();
      cpu_u.hv(16'hff7e, v);
      cpu_u.wr(8'h00, 8'h19);
      cpu_u.wr(8'h01, ~v);
      `CHK("start", {2'b11, v, 6'h00}, ps)
      cpu_u.rd(8'h01, x);
      `CHK("prot", v, x)
      t = 16'({2'b11, v, 6'h00} + $urandom % 32'h100 - 32'h80);
      cpu_u.hv(t, 8'h00);
      `CHK("hv", !hit(v, t), hv)
      cpu_u.rd(8'h07, x);
      `CHK("refused", hit(v, t), x[1])
      `CHK("tgt_hit", hit(v, t), x[2])
      cpu_u.wr(8'h00, 8'h00);
      cpu_u.wr(8'h00, 8'h06);
      cpu_u.wr(8'h00, 8'h0e);
      `CHK("mass", v == 8'hff, ms & hv)
    end
    for (int k = 0; k < 2; k++) begin
      reset_dut();
      wt <= k == 0;
      st <= k == 1;
      repeat (3) @(posedge clk);
      `CHK("idle", 1'b0, sb)
      wt <= 1'b0;
      st <= 1'b0;
      cpu_u.hv(16'h0000, 8'h00);
      wt <= k == 0;
      st <= k == 1;
      @(posedge clk);
      #1;
      `CHK("abort", 5'h10, {sb, pg, er, ms, hv})
      @(posedge clk);
      wt <= 1'b0;
      st <= 1'b0;
    end
    v = 8'($urandom);
    cpu_u.wr(8'h04, v);
    `CHK("trim", v, live)
    cpu_u.rd(8'h3c, x);
    `CHK("unmapped", 8'h00, x)
    conclude();
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
